// ---- include/acd_pkg.sv ----
/*
  Shared constants and types for the converter's digital control block:
  register offsets, field positions, reset values and the sample carrier.
  Assumes it is compiled before any design file that names it.
*/
package acd_pkg;

  // Register offsets on the serial port
  localparam logic [6:0] ADDR_FORMAT   = 7'h01;
  localparam logic [6:0] ADDR_TIMING   = 7'h03;
  localparam logic [6:0] ADDR_CHB_TERM = 7'h05;
  localparam logic [6:0] ADDR_CLK_FMT  = 7'h06;
  localparam logic [6:0] ADDR_RSVD     = 7'h07;
  localparam logic [6:0] ADDR_CM       = 7'h08;
  localparam logic [6:0] ADDR_SOFT_RST = 7'h0a;

  // Reset values
  localparam logic [7:0] RST_FORMAT    = 8'h00;
  localparam logic [7:0] RST_TIMING    = 8'hb6;
  localparam logic [7:0] RST_CHB_TERM  = 8'h00;
  localparam logic [7:0] RST_CLK_FMT   = 8'h00;
  localparam logic [7:0] RST_CM        = 8'h00;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h5a;

  // Field positions
  localparam int FMT_SINGLE_BUS   = 1;
  localparam int TM_ALIGNER_SKIP  = 7;
  localparam int TM_HALF_SHIFT    = 6;
  localparam int TM_STROBE_LSB    = 3;
  localparam int TM_DATA_LSB      = 0;
  localparam int TERM_STROBE_LSB  = 3;
  localparam int TERM_BUS_LSB     = 0;
  localparam int CF_PATTERN_SEL   = 7;
  localparam int CF_PATTERN_EN    = 6;
  localparam int CF_NUM_CODE_LSB  = 4;
  localparam int CF_CLOCK_TERM    = 3;
  localparam int CF_ALIGN_EDGE    = 2;
  localparam int CF_RATIO_LSB     = 0;
  localparam int CM_B_CONNECT     = 7;
  localparam int CM_B_LEVEL_LSB   = 4;
  localparam int CM_A_CONNECT     = 3;
  localparam int CM_A_LEVEL_LSB   = 0;

  // Timing counts
  localparam int          CONV_LATENCY = 9;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [4:0]  FRAME_LAST   = 5'd15;
  localparam logic [4:0]  CMD_LAST     = 5'd7;
  localparam logic [4:0]  DATA_FIRST   = 5'd8;

  // Test patterns
  localparam logic [7:0]  ALT_PATTERN_HI = 8'h55;
  localparam logic [7:0]  ALT_PATTERN_LO = 8'haa;

  typedef enum logic [1:0] {RATIO_BYPASS, RATIO_DIV2, RATIO_DIV4} acd_ratio_e;

  typedef enum logic {PH_FIRST, PH_SECOND} acd_phase_e;

  // One sample pair from both channels
  typedef struct packed {
    logic [7:0] a_data;
    logic       a_overrange_flag;
    logic [7:0] b_data;
    logic       b_overrange_flag;
  } acd_sample_s;

endpackage

// ---- hdl/acd_top.sv ----
/*
  Digital control of a dual 8-bit converter: serial register file, input
  clock divider with sync realignment, test patterns, number formats,
  9-sample latency pipe, 8-word output FIFO and output strobe.
  Assumes the converter core hands over offset-binary results on i_clock,
  and that the sync, mode, ratio, power-toggle and serial-port pins are asynchronous to i_clock.
*/
// Operation
// - Channel B strobe termination bits 5:3 pick 50/75/100/150, any 1xx picks 300.
// - Channel B bus termination bits 2:0 use same code, default 000; bits 7:6 ignored.
// - Pattern-choice clear gives offset-binary ramp 0..255 wrapping, then formatted.
// - Pattern-choice set alternates 01010101 with flag 1 and 10101010 with flag 0.
// - Pattern-enable bit 6 swaps conversion data for the test pattern.
// - Number code 00/11 two's complement, 01 offset binary, 10 Gray.
// - Ratio 00/11 bypass, 01 divide by 2, 10 divide by 4.
// - Align-method bit 2 picks slip at 0, edge at 1.
// - Slip mode skips one divider transition on third edge after sync rises.
// - Edge mode forces state 0 on third edge; divided clock rises edge 4 or 5.
// - Sample on sample-clock edge; result presented after nine sample clocks.
// - With division on, sampling and output follow the divided clock; output here is strobed on i_clock as the FIFO drains.
// - Serial-port-enable pin high takes the ratio from the ratio pins.
// - Each common-mode field holds connect bit and level code 0.9V up/down.
// - Writing 5Ah to address 0Ah resets all registers to defaults.
// - Data delay trim shifts data timing in sixteenth-period steps.
// - Strobe delay trim steps by sixteenths; equal trims put strobe T/8 early.
// - Half-period shift delays data T/2 except in single-bus mode.
// - Aligner-skip high bypasses the data aligner delay line.
// - Single-bus-select merges both channels onto one multiplexed bus.
// - Power-toggle falling edge while serial-port-enable high resets registers.

module acd_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      count;
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  wire              push = i_in_valid & o_in_ready;
  wire              pop  = o_out_valid & i_out_ready;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == LAST_SLOT) ? '0 : p + AW'(1);
  endfunction

  // Honest flags from the occupancy count
  assign o_in_ready  = (count != FULL_COUNT);
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];

  // Storage, no reset needed
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= step(wr_ptr);
      if (pop) rd_ptr <= step(rd_ptr);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module acd_top (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_sync,
  input  wire logic                 i_serial_port_enable,
  input  wire logic                 i_power_toggle_pin,
  input  wire logic [1:0]           i_ratio_pin,
  input  wire logic                 i_spi_cs_n,
  input  wire logic                 i_spi_sclk,
  input  wire logic                 i_spi_sdio,
  output logic                      o_spi_sdio,
  output logic                      o_spi_sdio_oe,
  input  wire acd_pkg::acd_sample_s i_conv,
  input  wire logic                 i_capture_ready,
  output acd_pkg::acd_sample_s      o_bus,
  output logic                      o_data_out_strobe,
  output logic                      o_fifo_ready,
  output logic                      o_sample_tick,
  output logic [4:0]                o_chb_strobe_term_sel,
  output logic [4:0]                o_chb_bus_term_sel,
  output logic                      o_clock_term,
  output logic                      o_cha_cm_connect,
  output logic [10:0]               o_cha_cm_level_mv,
  output logic                      o_chb_cm_connect,
  output logic [10:0]               o_chb_cm_level_mv,
  output logic [2:0]                o_data_delay_trim,
  output logic [2:0]                o_strobe_delay_trim,
  output logic                      o_half_period_shift,
  output logic                      o_aligner_skip
);
  // Termination one-hot: 50,75,100,150,300 ohm from bit 0 up
  function automatic logic [4:0] term_of(input logic [2:0] code);
    term_of = code[2] ? 5'h10 : (5'h01 << code[1:0]);
  endfunction

  // Common-mode level in millivolts
  function automatic logic [10:0] cm_mv(input logic [2:0] code);
    case (code)
      3'h1:    cm_mv = 11'd1050;
      3'h2:    cm_mv = 11'd1200;
      3'h3:    cm_mv = 11'd1350;
      3'h5:    cm_mv = 11'd750;
      3'h6:    cm_mv = 11'd600;
      3'h7:    cm_mv = 11'd450;
      default: cm_mv = 11'd900;
    endcase
  endfunction

  function automatic acd_pkg::acd_ratio_e ratio_of(input logic [1:0] code);
    case (code)
      2'h1:    ratio_of = acd_pkg::RATIO_DIV2;
      2'h2:    ratio_of = acd_pkg::RATIO_DIV4;
      default: ratio_of = acd_pkg::RATIO_BYPASS;
    endcase
  endfunction

  // Offset binary in, selected number code out
  function automatic logic [7:0] encode(input logic [7:0] ob, input logic [1:0] code);
    case (code)
      2'h1:    encode = ob;
      2'h2:    encode = ob ^ (ob >> 1);
      default: encode = {~ob[7], ob[6:0]};
    endcase
  endfunction

  // Pin synchronisers: first stage read only by second
  logic [1:0] sync_ff, serial_port_enable_ff, pwr_ff, cs_ff, sclk_ff, sdi_ff, rp0_ff, rp1_ff;
  logic       sync_q, pwr_q, sclk_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_ff <= '0; serial_port_enable_ff <= '0; pwr_ff <= '0; cs_ff <= 2'h3; sclk_ff <= '0;
      sdi_ff <= '0; rp0_ff <= '0; rp1_ff <= '0; sync_q <= 1'b0; pwr_q <= 1'b0; sclk_q <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[0], i_sync};
      serial_port_enable_ff <= {serial_port_enable_ff[0], i_serial_port_enable};
      pwr_ff  <= {pwr_ff[0], i_power_toggle_pin};
      cs_ff   <= {cs_ff[0], i_spi_cs_n};
      sclk_ff <= {sclk_ff[0], i_spi_sclk};
      sdi_ff  <= {sdi_ff[0], i_spi_sdio};
      rp0_ff  <= {rp0_ff[0], i_ratio_pin[0]};
      rp1_ff  <= {rp1_ff[0], i_ratio_pin[1]};
      sync_q  <= sync_ff[1];
      pwr_q   <= pwr_ff[1];
      sclk_q  <= sclk_ff[1];
    end
  end

  wire serial_port_enable_s   = serial_port_enable_ff[1];
  wire sync_go  = sync_ff[1] & ~sync_q;          // acted on at third edge after sync rises
  wire pwr_fall = ~pwr_ff[1] & pwr_q;
  wire sclk_up  = sclk_ff[1] & ~sclk_q & ~cs_ff[1] & ~serial_port_enable_s;
  wire sclk_dn  = ~sclk_ff[1] & sclk_q & ~cs_ff[1] & ~serial_port_enable_s;

  // Serial port frame: rw bit, 7-bit address, 8 data bits, MSB first
  logic [14:0] shreg;
  logic [4:0]  bit_cnt;
  logic        rd_mode;
  logic [7:0]  rd_word;
  logic [7:0]  rd_value;
  wire [15:0]  frame    = {shreg, sdi_ff[1]};
  wire         wr_en    = sclk_up & (bit_cnt == acd_pkg::FRAME_LAST) & ~frame[15];
  wire [6:0]   wr_addr  = frame[14:8];
  wire [7:0]   wr_data  = frame[7:0];
  wire [6:0]   cmd_addr = frame[6:0];

  // Register file
  logic [7:0] fmt01, tm03, term05, clk06, cm08;
  wire soft_rst = wr_en & (wr_addr == acd_pkg::ADDR_SOFT_RST)
                  & (wr_data == acd_pkg::SOFT_RESET_CODE);
  wire pin_rst  = serial_port_enable_s & pwr_fall;
  wire reg_rst  = soft_rst | pin_rst;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fmt01 <= acd_pkg::RST_FORMAT; tm03 <= acd_pkg::RST_TIMING; term05 <= acd_pkg::RST_CHB_TERM;
      clk06 <= acd_pkg::RST_CLK_FMT; cm08 <= acd_pkg::RST_CM;
    end else if (reg_rst) begin
      fmt01 <= acd_pkg::RST_FORMAT; tm03 <= acd_pkg::RST_TIMING; term05 <= acd_pkg::RST_CHB_TERM;
      clk06 <= acd_pkg::RST_CLK_FMT; cm08 <= acd_pkg::RST_CM;
    end else if (wr_en) begin
      // Reserved slot 07h has no storage, writes there fall through
      if (wr_addr == acd_pkg::ADDR_FORMAT) fmt01 <= wr_data;
      else if (wr_addr == acd_pkg::ADDR_TIMING) tm03 <= wr_data;
      else if (wr_addr == acd_pkg::ADDR_CHB_TERM) term05 <= {2'h0, wr_data[5:0]};
      else if (wr_addr == acd_pkg::ADDR_CLK_FMT) clk06 <= wr_data;
      else if (wr_addr == acd_pkg::ADDR_CM) cm08 <= wr_data;
    end
  end

  // Divider state and ratio selection
  logic [1:0]          div_cnt;
  logic                div_clk;
  acd_pkg::acd_ratio_e ratio;
  assign ratio = serial_port_enable_s ? ratio_of({rp1_ff[1], rp0_ff[1]})
                        : ratio_of(clk06[acd_pkg::CF_RATIO_LSB +: 2]);

  // Read decode; reserved slot shows divider state and FIFO ready
  always_comb begin
    if (cmd_addr == acd_pkg::ADDR_FORMAT) rd_value = fmt01;
    else if (cmd_addr == acd_pkg::ADDR_TIMING) rd_value = tm03;
    else if (cmd_addr == acd_pkg::ADDR_CHB_TERM) rd_value = term05;
    else if (cmd_addr == acd_pkg::ADDR_CLK_FMT) rd_value = clk06;
    else if (cmd_addr == acd_pkg::ADDR_RSVD) rd_value = {4'h0, div_cnt, div_clk, o_fifo_ready};
    else if (cmd_addr == acd_pkg::ADDR_CM) rd_value = cm08;
    else rd_value = 8'h00;
  end

  // Serial shifter and read-back driver
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg <= '0; bit_cnt <= '0; rd_mode <= 1'b0; rd_word <= '0;
      o_spi_sdio <= 1'b0; o_spi_sdio_oe <= 1'b0;
    end else if (cs_ff[1] | serial_port_enable_s) begin
      bit_cnt <= '0; rd_mode <= 1'b0; o_spi_sdio_oe <= 1'b0;
    end else begin
      if (sclk_up) begin
        shreg   <= frame[14:0];
        bit_cnt <= bit_cnt + 5'd1;
        if (bit_cnt == acd_pkg::CMD_LAST) begin
          rd_mode <= frame[7];
          rd_word <= rd_value;
        end
      end
      if (sclk_dn & rd_mode & (bit_cnt >= acd_pkg::DATA_FIRST)) begin
        o_spi_sdio    <= rd_word[7];
        rd_word       <= {rd_word[6:0], 1'b0};
        o_spi_sdio_oe <= 1'b1;
      end
    end
  end

  // Divider counter, advanced every input edge except in bypass or on sync
  wire edge_mode = clk06[acd_pkg::CF_ALIGN_EDGE];
  logic [1:0] next_div_cnt;
  always_comb begin
    if (ratio == acd_pkg::RATIO_BYPASS) next_div_cnt = 2'h0;
    else if (sync_go & edge_mode) next_div_cnt = 2'h0;
    else if (sync_go) next_div_cnt = div_cnt;
    else if (ratio == acd_pkg::RATIO_DIV2) next_div_cnt = {1'b0, ~div_cnt[0]};
    else next_div_cnt = div_cnt + 2'h1;
  end
  wire next_div_clk = (ratio == acd_pkg::RATIO_DIV2) ? next_div_cnt[0] : next_div_cnt[1];
  wire sample_en    = (ratio == acd_pkg::RATIO_BYPASS) | (next_div_clk & ~div_clk);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= '0; div_clk <= 1'b0; o_sample_tick <= 1'b0;
    end else begin
      div_cnt       <= next_div_cnt;
      div_clk       <= (ratio == acd_pkg::RATIO_BYPASS) ? 1'b0 : next_div_clk;
      o_sample_tick <= sample_en;
    end
  end

  // Nine-sample latency pipe, advanced only by sample-clock edges
  acd_pkg::acd_sample_s pipe [acd_pkg::CONV_LATENCY];
  logic [7:0] ramp;
  logic       alt_phase;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < acd_pkg::CONV_LATENCY; i++) pipe[i] <= '0;
      ramp <= '0; alt_phase <= 1'b0;
    end else if (sample_en) begin
      pipe[0] <= i_conv;
      for (int i = 1; i < acd_pkg::CONV_LATENCY; i++) pipe[i] <= pipe[i-1];
      ramp      <= ramp + 8'h01;
      alt_phase <= ~alt_phase;
    end
  end

  // Pattern substitution and number format
  wire        pat_en   = clk06[acd_pkg::CF_PATTERN_EN];
  wire        pat_alt  = clk06[acd_pkg::CF_PATTERN_SEL];
  wire [1:0]  num_code = clk06[acd_pkg::CF_NUM_CODE_LSB +: 2];
  wire [7:0]  alt_data = alt_phase ? acd_pkg::ALT_PATTERN_LO : acd_pkg::ALT_PATTERN_HI;
  wire [7:0]  src_a    = pat_en ? ramp : pipe[acd_pkg::CONV_LATENCY-1].a_data;
  wire [7:0]  src_b    = pat_en ? ramp : pipe[acd_pkg::CONV_LATENCY-1].b_data;
  acd_pkg::acd_sample_s push_word;
  assign push_word.a_data = (pat_en & pat_alt) ? alt_data : encode(src_a, num_code);
  assign push_word.b_data = (pat_en & pat_alt) ? alt_data : encode(src_b, num_code);
  assign push_word.a_overrange_flag = pat_en ? (pat_alt & ~alt_phase)
                                             : pipe[acd_pkg::CONV_LATENCY-1].a_overrange_flag;
  assign push_word.b_overrange_flag = pat_en ? (pat_alt & ~alt_phase)
                                             : pipe[acd_pkg::CONV_LATENCY-1].b_overrange_flag;

  // Output FIFO; the capturing side may stall it
  logic                 fifo_in_ready, fifo_out_valid;
  acd_pkg::acd_sample_s fifo_out;
  acd_pkg::acd_phase_e  phase;
  wire single_bus = fmt01[acd_pkg::FMT_SINGLE_BUS];
  wire drain      = i_capture_ready & ((phase == acd_pkg::PH_SECOND) | ~single_bus);

  acd_fifo #(
    .WIDTH ($bits(acd_pkg::acd_sample_s)),
    .DEPTH (acd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (sample_en),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_word),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (drain),
    .o_out_data  (fifo_out)
  );

  // Output presentation: dual bus, or A then B on bus A
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus <= '0; o_data_out_strobe <= 1'b0; phase <= acd_pkg::PH_FIRST;
    end else begin
      o_data_out_strobe <= 1'b0;
      if (fifo_out_valid & i_capture_ready) begin
        o_data_out_strobe <= 1'b1;
        case (phase)
          acd_pkg::PH_FIRST: begin
            if (single_bus) begin
              o_bus <= '{fifo_out.a_data, fifo_out.a_overrange_flag, 8'h00, 1'b0};
              phase <= acd_pkg::PH_SECOND;
            end else begin
              o_bus <= fifo_out;
            end
          end
          default: begin
            o_bus <= '{fifo_out.b_data, fifo_out.b_overrange_flag, 8'h00, 1'b0};
            phase <= acd_pkg::PH_FIRST;
          end
        endcase
      end
    end
  end

  // Static configuration toward the analog and pad cells
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fifo_ready <= 1'b0; o_chb_strobe_term_sel <= '0; o_chb_bus_term_sel <= '0;
      o_clock_term <= 1'b0; o_cha_cm_connect <= 1'b0; o_cha_cm_level_mv <= '0;
      o_chb_cm_connect <= 1'b0; o_chb_cm_level_mv <= '0; o_data_delay_trim <= '0;
      o_strobe_delay_trim <= '0; o_half_period_shift <= 1'b0; o_aligner_skip <= 1'b0;
    end else begin
      o_fifo_ready          <= fifo_in_ready;
      o_chb_strobe_term_sel <= term_of(term05[acd_pkg::TERM_STROBE_LSB +: 3]);
      o_chb_bus_term_sel    <= term_of(term05[acd_pkg::TERM_BUS_LSB +: 3]);
      o_clock_term          <= clk06[acd_pkg::CF_CLOCK_TERM];
      o_cha_cm_connect      <= cm08[acd_pkg::CM_A_CONNECT];
      o_cha_cm_level_mv     <= cm_mv(cm08[acd_pkg::CM_A_LEVEL_LSB +: 3]);
      o_chb_cm_connect      <= cm08[acd_pkg::CM_B_CONNECT];
      o_chb_cm_level_mv     <= cm_mv(cm08[acd_pkg::CM_B_LEVEL_LSB +: 3]);
      o_data_delay_trim     <= tm03[acd_pkg::TM_DATA_LSB +: 3];
      o_strobe_delay_trim   <= tm03[acd_pkg::TM_STROBE_LSB +: 3];
      o_half_period_shift   <= tm03[acd_pkg::TM_HALF_SHIFT] & ~single_bus;
      o_aligner_skip        <= tm03[acd_pkg::TM_ALIGNER_SKIP];
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence sync_slip_s;
    sync_go && !edge_mode && ratio != acd_pkg::RATIO_BYPASS;
  endsequence
  sequence sync_edge_s;
    sync_go && edge_mode && ratio != acd_pkg::RATIO_BYPASS;
  endsequence

  edge_force_zero_a: assert property (sync_edge_s |=> div_cnt == 2'h0)
    else $error("edge sync did not clear divider");
  slip_hold_a: assert property (sync_slip_s |=> div_cnt == $past(div_cnt))
    else $error("slip sync did not hold divider");
  div4_period_a: assert property (sample_en && ratio == acd_pkg::RATIO_DIV4 && !sync_go
    ##1 (ratio == acd_pkg::RATIO_DIV4 && !sync_go) [*3] |-> !sample_en)
    else $error("divide by four ticked early");
  soft_reset_a: assert property (soft_rst |=> clk06 == acd_pkg::RST_CLK_FMT
    && tm03 == acd_pkg::RST_TIMING)
    else $error("soft reset key did not restore defaults");
  pin_reset_a: assert property (pin_rst |=> cm08 == acd_pkg::RST_CM)
    else $error("power toggle reset missed");
  ramp_step_a: assert property (sample_en |=> ramp == $past(ramp) + 8'h01)
    else $error("ramp did not step");
  pin_ratio_a: assert property (serial_port_enable_s && {rp1_ff[1], rp0_ff[1]} == 2'h1 |-> ratio == acd_pkg::RATIO_DIV2)
    else $error("pin mode ratio ignored");
  half_shift_mux_a: assert property ($past(single_bus) |-> !o_half_period_shift)
    else $error("half period shift active in single bus mode");
  term_code_a: assert property (##1 term05[5] |=> o_chb_strobe_term_sel == 5'h10)
    else $error("strobe termination not 300 ohm");
endmodule

// ---- testbench/acd_capture_model.sv ----
/*
  Model of the capturing party: takes each word on the output strobe
  and stalls the FIFO drain at random.
  Assumes it shares the block's clock and reset.
*/
module acd_capture_model (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  input  wire acd_pkg::acd_sample_s i_bus,
  input  wire logic                 i_strobe,
  output logic                      o_ready,
  output logic                      o_got,
  output acd_pkg::acd_sample_s      o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Capture on the strobe cycle, ready low one cycle in eight
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_got   <= 1'b0;
      o_word  <= '0;
    end else begin
      o_ready <= ($urandom % 8) != 0;
      o_got   <= i_strobe;
      if (i_strobe) begin
        o_word <= i_bus;
      end
    end
  end
endmodule

// ---- testbench/adc_clock_divider_output_config_bench.sv ----
/*
  Self-checking bench: registers over the serial port, ratio, patterns, resets.
  Assumes the block's serial frame timing and the capture model beside it.
*/
module adc_clock_divider_output_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_sync = 1'b0, i_serial_port_enable = 1'b0;
  logic i_power_toggle_pin = 1'b0, i_spi_cs_n = 1'b1, i_spi_sclk = 1'b0, i_spi_sdio = 1'b0;
  logic [1:0] i_ratio_pin = 2'h0;
  logic i_capture_ready, o_data_out_strobe, o_sample_tick, got, first;
  logic [4:0] o_chb_strobe_term_sel, o_chb_bus_term_sel;
  logic [10:0] o_cha_cm_level_mv, o_chb_cm_level_mv;
  logic o_cha_cm_connect, o_chb_cm_connect;
  logic [2:0] o_data_delay_trim, o_strobe_delay_trim;
  logic o_spi_sdio, o_spi_sdio_oe, o_fifo_ready, o_half_period_shift, o_aligner_skip, roe;
  logic [1:0] fc;
  logic [10:0] sc;
  acd_pkg::acd_sample_s i_conv = '0, o_bus, w;
  logic [7:0] v, prev, rdat;
  int n_fail = 0, checked = 0, mode = 0;
  logic [10:0] mvt [8] = '{11'h384, 11'h41a, 11'h4b0, 11'h546, 11'h384, 11'h2ee, 11'h258, 11'h1c2};
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) i_conv <= 18'($urandom);
  acd_top DUT (.i_clock, .i_rst_n, .i_sync, .i_serial_port_enable, .i_power_toggle_pin,
    .i_ratio_pin, .i_spi_cs_n, .i_spi_sclk, .i_spi_sdio, .o_spi_sdio, .o_spi_sdio_oe, .i_conv,
    .i_capture_ready, .o_bus, .o_data_out_strobe, .o_fifo_ready, .o_sample_tick,
    .o_chb_strobe_term_sel, .o_chb_bus_term_sel, .o_clock_term(), .o_cha_cm_connect,
    .o_cha_cm_level_mv, .o_chb_cm_connect, .o_chb_cm_level_mv, .o_data_delay_trim,
    .o_strobe_delay_trim, .o_half_period_shift, .o_aligner_skip);
  acd_capture_model PEER (.i_clock, .i_rst_n, .i_bus(o_bus), .i_strobe(o_data_out_strobe),
    .o_ready(i_capture_ready), .o_got(got), .o_word(w));
  function automatic logic [10:0] term(input logic [2:0] c);
    return 11'(c[2] ? 5'h10 : 5'h01 << c[1:0]);
  endfunction
  // Ramp count in the chosen number code
  function automatic logic [7:0] fmt(input logic [7:0] n, input logic [1:0] c);
    return c == 2'h1 ? n : c == 2'h2 ? n ^ (n >> 1) : n ^ 8'h80;
  endfunction
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  // One 16-bit frame, MSB first, slow serial clock; read bits taken before each rise
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic rw = 1'b0);
    logic [15:0] f;
    f = {rw, a, d};
    i_spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      i_spi_sdio <= f[i];
      i_spi_sclk <= 1'b0;
      repeat (5) @(posedge i_clock);
      if (i < 8) rdat[i] = o_spi_sdio;
      roe = o_spi_sdio_oe;
      i_spi_sclk <= 1'b1;
      repeat (5) @(posedge i_clock);
    end
    i_spi_sclk <= 1'b0;
    repeat (5) @(posedge i_clock);
    i_spi_cs_n <= 1'b1;
    repeat (12) @(posedge i_clock);
  endtask
  // Sample ticks seen in 40 cycles
  task automatic ticks(input logic [10:0] e);
    int c;
    c = 0;
    repeat (20) @(posedge i_clock);
    repeat (40) begin
      @(posedge i_clock);
      c += int'(o_sample_tick);
    end
    chk("ticks", e, 11'(c));
  endtask
  task automatic end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Captured words checked against the active pattern
  always @(posedge i_clock) if (got) begin
    if (mode == 1 || mode == 3) begin
      chk("alt_a", w.a_overrange_flag ? 11'h55 : 11'haa, 11'(w.a_data));
      if (mode == 1) chk("alt_b", w.b_overrange_flag ? 11'h55 : 11'haa, 11'(w.b_data));
      else chk("mux_b", 11'h0, 11'({w.b_data, w.b_overrange_flag}));
    end else if (mode == 2) begin
      if (first) begin
        for (int k = 0; k < 256; k++) begin
          if (fmt(8'(k), fc) == w.a_data) prev = 8'(k) - 8'h01;
        end
      end
      first = 1'b0;
      prev = prev + 8'h01;
      chk("ramp", 11'(fmt(prev, fc)), 11'(w.a_data));
    end
  end
  initial begin
    repeat (60000) @(posedge i_clock);
    n_fail++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h1f87));
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    chk("bus_term", 11'h01, 11'(o_chb_bus_term_sel));
    chk("fifo_rdy", 11'h1, 11'(o_fifo_ready));
    repeat (4) begin
      v = 8'($urandom);
      wr(acd_pkg::ADDR_CHB_TERM, v);
      chk("strobe_term", term(v[5:3]), 11'(o_chb_strobe_term_sel));
      chk("bus_term", term(v[2:0]), 11'(o_chb_bus_term_sel));
      wr(acd_pkg::ADDR_CM, v);
      chk("cm_a", mvt[v[2:0]], o_cha_cm_level_mv);
      chk("cm_b", {v[7], mvt[v[6:4]]}, {o_chb_cm_connect, o_chb_cm_level_mv});
      wr(acd_pkg::ADDR_CM, 8'h00, 1'b1);
      chk("rd_cm", 11'(v), 11'(rdat));
    end
    // Unmapped address; the reserved slot is never written
    wr(7'h7f, 8'h00);
    wr(acd_pkg::ADDR_SOFT_RST, 8'h33);
    chk("bus_term", term(v[2:0]), 11'(o_chb_bus_term_sel));
    wr(acd_pkg::ADDR_SOFT_RST, acd_pkg::SOFT_RESET_CODE);
    chk("bus_term", 11'h01, 11'(o_chb_bus_term_sel));
    chk("cm_a", 11'h384, o_cha_cm_level_mv);
    chk("trim", 11'h6, 11'(o_data_delay_trim));
    wr(acd_pkg::ADDR_TIMING, 8'h00, 1'b1);
    chk("rd_tm", 11'hb6, 11'(rdat));
    chk("rd_oe", 11'h1, 11'(roe));
    for (int r = 0; r < 4; r++) begin
      wr(acd_pkg::ADDR_CLK_FMT, 8'(r));
      ticks(r == 1 ? 11'd20 : r == 2 ? 11'd10 : 11'd40);
    end
    wr(acd_pkg::ADDR_CLK_FMT, 8'hc0);
    repeat (40) @(posedge i_clock);
    mode = 1;
    repeat (200) @(posedge i_clock);
    mode = 0;
    // Single bus with equal trims and aligner skip, then dual bus again
    wr(acd_pkg::ADDR_FORMAT, 8'h02);
    wr(acd_pkg::ADDR_TIMING, 8'hed);
    chk("timing", 11'had, 11'({o_aligner_skip, o_half_period_shift, o_strobe_delay_trim, o_data_delay_trim}));
    mode = 3;
    repeat (200) @(posedge i_clock);
    mode = 0;
    wr(acd_pkg::ADDR_FORMAT, 8'h00);
    chk("timing", 11'hed, 11'({o_aligner_skip, o_half_period_shift, o_strobe_delay_trim, o_data_delay_trim}));
    // Ramp in every number code, divide by four
    for (int k = 0; k < 4; k++) begin
      fc = 2'(k);
      wr(acd_pkg::ADDR_CLK_FMT, {2'h1, fc, 4'h2});
      repeat (80) @(posedge i_clock);
      first = 1'b1;
      mode = 2;
      repeat (200) @(posedge i_clock);
      mode = 0;
    end
    // Edge sync ticks on the fifth edge; slip exercises the hold check
    for (int s = 0; s < 2; s++) begin
      wr(acd_pkg::ADDR_CLK_FMT, s ? 8'h02 : 8'h06);
      i_sync <= 1'b1;
      sc = '0;
      repeat (3) @(posedge i_clock);
      repeat (3) begin
        @(posedge i_clock);
        sc = {sc[9:0], o_sample_tick};
      end
      if (s == 0) chk("edge_sync", 11'h1, sc);
      i_sync <= 1'b0;
      repeat (8) @(posedge i_clock);
    end
    wr(acd_pkg::ADDR_CHB_TERM, 8'h24);
    i_serial_port_enable <= 1'b1;
    i_ratio_pin <= 2'h1;
    ticks(11'd20);
    i_power_toggle_pin <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_power_toggle_pin <= 1'b0;
    repeat (10) @(posedge i_clock);
    chk("bus_term", 11'h01, 11'(o_chb_bus_term_sel));
    end_of_test;
  end
endmodule
